//--- shared/substrate_shutter_regs.vh
`ifndef SUBSTRATE_SHUTTER_REGS_VH
`define SUBSTRATE_SHUTTER_REGS_VH

// Register offsets
`define EXPOSE_MASK_OFFSET       8'h74
`define PULSE_COUNT_OFFSET       8'h75
`define PRIMARY_ACTION_OFFSET    8'h70

// Field widths
`define POS_W                    13
`define CNT_W                    13
`define ACTION_W                 3

// Primary counter action codes
`define ACTION_NONE              3'h0
`define ACTION_SINGLE            3'h1
`define ACTION_REPEAT            3'h2
`define ACTION_DELAYED           3'h3
`define ACTION_DELAYED_REPEAT    3'h4
`define ACTION_MANUAL_EXPOSE     3'h5
`define ACTION_MANUAL_READ       3'h6
`define ACTION_FORCE_IDLE        3'h7

// Reset values, and the start line value that is not to be written
`define FINE_TOGGLE_OFF          13'h1fff
`define SKIP_FIRST_RESET         1'h0
`define START_LINE_NEXT          13'h0000
`define START_LINE_INVALID       13'h0001

`endif

//--- hdl/toggle_window.v
`timescale 1ns/1ps
`default_nettype none

// High between the two toggle positions of a line, whichever order they have
module toggle_window #(
    parameter POS_W = 13
) (
    // Pixel position and toggles
    input  wire [POS_W-1:0] pos_i,
    input  wire [POS_W-1:0] first_i,
    input  wire [POS_W-1:0] second_i,
    // Result
    output wire             inside_o
);

    assign inside_o = (pos_i >= first_i) ^ (pos_i >= second_i);

endmodule // toggle_window

`default_nettype wire

//--- hdl/field_mask_counter.v
`timescale 1ns/1ps
`default_nettype none

// Counts a mask duration down in whole fields
module field_mask_counter #(
    parameter CNT_W = 13
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // Control
    input  wire             load_i,
    input  wire [CNT_W-1:0] count_i,
    input  wire             tick_i,
    input  wire             hold_i,
    input  wire             clear_i,
    // State
    output wire             active_o
);

    reg [CNT_W-1:0] remaining;

    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            remaining <= {CNT_W{1'b0}};
        end
        else if (clear_i)
        begin
            remaining <= {CNT_W{1'b0}};
        end
        else if (load_i)
        begin
            remaining <= count_i;
        end
        else if (tick_i && !hold_i && remaining != {CNT_W{1'b0}})
        begin
            remaining <= remaining - {{(CNT_W-1){1'b0}}, 1'b1}; // R21
        end
    end

    assign active_o = (remaining != {CNT_W{1'b0}}) || hold_i; // R21

endmodule // field_mask_counter

`default_nettype wire

//--- hdl/substrate_shutter.v
`timescale 1ns/1ps
`default_nettype none
`include "substrate_shutter_regs.vh"

// Notes on behaviour
// R01 - Substrate pulses run every field by default
// R02 - One pulse per line, count from register
// R03 - Start polarity, toggle at two pixel positions
// R04 - Pulses start after primary gate active line
// R05 - Start line 0 next line, N delays
// R06 - Shadow values load on line after gate
// R07 - Extra fine pulse in last pulsed line
// R08 - Fine toggles at maximum disable extra pulse
// R09 - Fine toggles update at gate or field
// R10 - Software activates primary counter for low speed
// R11 - Gate masked for exposure field count
// R12 - Substrate masked for expose plus read count
// R13 - Masks apply from the following field
// R14 - Skip bit delays masks by one field
// R15 - Zero durations leave outputs unchanged
// R16 - Secondary counter never touches these outputs
// R17 - Sensor gate pulses every field by default
// R18 - Gate suppress keeps substrate train running
// R19 - Action 1 counts once, 7 idles
// R20 - Action 5 masks until readout or idle
// R21 - Masks count whole fields, then release
module substrate_shutter #(
    parameter POS_W = `POS_W,
    parameter CNT_W = `CNT_W
) (
    // Clock and reset
    input  wire                  clk_i,
    input  wire                  rst_i,
    // Timing from the field and line generator
    input  wire                  field_sync_i,
    input  wire                  line_start_i,
    input  wire [CNT_W-1:0]      primary_gate_active_line_i,
    input  wire                  sensor_gate_i,
    // Substrate pulse settings
    input  wire                  pulse_start_polarity_i,
    input  wire [POS_W-1:0]      pulse_toggle_first_i,
    input  wire [POS_W-1:0]      pulse_toggle_second_i,
    input  wire [CNT_W-1:0]      pulses_per_field_i,
    input  wire [CNT_W-1:0]      pulse_start_line_i,
    input  wire                  gate_suppress_i,
    // Fine pulse settings
    input  wire [POS_W-1:0]      fine_toggle_first_i,
    input  wire [POS_W-1:0]      fine_toggle_second_i,
    input  wire                  fine_update_at_field_i,
    // Low speed settings
    input  wire [CNT_W-1:0]      exposure_field_count_i,
    input  wire [CNT_W-1:0]      expose_read_field_count_i,
    input  wire                  skip_first_mask_i,
    input  wire [CNT_W-1:0]      primary_max_i,
    input  wire                  primary_action_write_i,
    input  wire [`ACTION_W-1:0]  primary_action_i,
    // Outputs to the vertical driver
    output reg                   substrate_clock_o,
    output reg                   vertical_sensor_gate_o,
    // Status
    output reg                   primary_busy_o,
    output reg                   substrate_masked_o,
    output reg                   gate_masked_o
);

    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_ARMED  = 2'h1;
    localparam [1:0] ST_RUN    = 2'h2;
    localparam [1:0] ST_MANUAL = 2'h3;

    localparam [CNT_W:0] ONE_WIDE = {{CNT_W{1'b0}}, 1'b1};

    reg  [POS_W-1:0]   pixel;
    reg  [CNT_W-1:0]   line;
    reg  [CNT_W-1:0]   lines_after;
    reg                after_gate;

    reg                polarity;
    reg  [POS_W-1:0]   toggle_first;
    reg  [POS_W-1:0]   toggle_second;
    reg  [CNT_W-1:0]   pulse_count;
    reg  [CNT_W-1:0]   start_line;
    reg                suppress;
    reg  [POS_W-1:0]   fine_first;
    reg  [POS_W-1:0]   fine_second;

    reg  [1:0]         state;
    reg  [CNT_W-1:0]   field_count;
    reg                skip_pending;
    reg                manual_expose;
    reg                manual_read;

    wire               gate_line_end;
    wire [CNT_W:0]     first_line;
    wire [CNT_W:0]     end_line;
    wire [CNT_W:0]     here;
    wire               pulse_line;
    wire               last_line;
    wire               fine_enabled;
    wire               normal_inside;
    wire               fine_inside;
    wire               mask_start;
    wire               expose_active;
    wire               read_active;
    wire               force_idle;
    wire               read_start;
    reg                next_substrate;

    // The line that follows the primary gate line starts here
    assign gate_line_end = line_start_i && !field_sync_i
                           && (line == primary_gate_active_line_i); // R04

    // Pixel position within the line and line number within the field
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pixel <= {POS_W{1'b0}};
            line  <= {CNT_W{1'b0}};
        end
        else
        begin
            if (line_start_i || field_sync_i)
            begin
                pixel <= {POS_W{1'b0}};
            end
            else if (pixel != {POS_W{1'b1}})
            begin
                pixel <= pixel + {{(POS_W-1){1'b0}}, 1'b1};
            end
            if (field_sync_i)
            begin
                line <= {CNT_W{1'b0}};
            end
            else if (line_start_i && line != {CNT_W{1'b1}})
            begin
                line <= line + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Lines counted from the gate line; 1 is the line right after it
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lines_after <= {CNT_W{1'b0}};
            after_gate  <= 1'b0;
        end
        else if (field_sync_i)
        begin
            lines_after <= {CNT_W{1'b0}};
            after_gate  <= 1'b0;
        end
        else if (gate_line_end)
        begin
            lines_after <= {{(CNT_W-1){1'b0}}, 1'b1};
            after_gate  <= 1'b1;
        end
        else if (line_start_i && after_gate && lines_after != {CNT_W{1'b1}})
        begin
            lines_after <= lines_after + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Working copies of the settings, taken at the line after the gate line; fine toggles at field sync if fine_update_at_field_i
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            polarity      <= 1'b0;
            toggle_first  <= {POS_W{1'b0}};
            toggle_second <= {POS_W{1'b0}};
            pulse_count   <= {CNT_W{1'b0}};
            start_line    <= `START_LINE_NEXT;
            suppress      <= 1'b0;
            fine_first    <= `FINE_TOGGLE_OFF;
            fine_second   <= `FINE_TOGGLE_OFF;
        end
        else
        begin
            if (gate_line_end)
            begin
                polarity      <= pulse_start_polarity_i; // R06
                toggle_first  <= pulse_toggle_first_i;   // R06
                toggle_second <= pulse_toggle_second_i;  // R06
                pulse_count   <= pulses_per_field_i;     // R06
                start_line    <= pulse_start_line_i;     // R06
                suppress      <= gate_suppress_i;        // R06
            end
            if (fine_update_at_field_i ? field_sync_i : gate_line_end) // R09
            begin
                fine_first  <= fine_toggle_first_i;
                fine_second <= fine_toggle_second_i;
            end
        end
    end

    // Value 0 means the very next line; 1 is not to be written
    assign first_line = (start_line == `START_LINE_NEXT) ? ONE_WIDE
                        : {1'b0, start_line}; // R05
    assign end_line   = first_line + {1'b0, pulse_count};
    assign here       = {1'b0, lines_after};
    assign pulse_line = after_gate && (here >= first_line)
                        && (here < end_line); // R02
    assign last_line  = pulse_line && (here + ONE_WIDE == end_line); // R07

    // Both fine toggles at their maximum switch the extra pulse off
    assign fine_enabled = !((fine_first == `FINE_TOGGLE_OFF)
                            && (fine_second == `FINE_TOGGLE_OFF)); // R08

    toggle_window #(
        .POS_W    (POS_W)
    ) u_normal_window (
        .pos_i    (pixel),
        .first_i  (toggle_first),
        .second_i (toggle_second),
        .inside_o (normal_inside)
    );

    toggle_window #(
        .POS_W    (POS_W)
    ) u_fine_window (
        .pos_i    (pixel),
        .first_i  (fine_first),
        .second_i (fine_second),
        .inside_o (fine_inside)
    );

    // Primary field counter; only its actions drive the masks
    assign force_idle = primary_action_write_i
                        && primary_action_i == `ACTION_FORCE_IDLE; // R19
    // Readout loads the substrate mask on the write itself, so it does not drop there unless expose_read_field_count_i is 0
    assign read_start = primary_action_write_i && state == ST_MANUAL
                        && primary_action_i == `ACTION_MANUAL_READ; // R20

    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state         <= ST_IDLE;
            field_count   <= {CNT_W{1'b0}};
            skip_pending  <= `SKIP_FIRST_RESET;
            manual_expose <= 1'b0;
            manual_read   <= 1'b0;
        end
        else if (force_idle)
        begin
            state         <= ST_IDLE; // R19
            field_count   <= {CNT_W{1'b0}};
            skip_pending  <= 1'b0;
            manual_expose <= 1'b0;
            manual_read   <= 1'b0;
        end
        else if (primary_action_write_i && primary_action_i != `ACTION_NONE
                 && primary_action_i != `ACTION_MANUAL_READ)
        begin
            state         <= ST_ARMED; // R10
            field_count   <= {CNT_W{1'b0}};
            skip_pending  <= skip_first_mask_i;
            manual_expose <= (primary_action_i == `ACTION_MANUAL_EXPOSE);
            manual_read   <= 1'b0;
        end
        else if (primary_action_write_i && primary_action_i == `ACTION_MANUAL_READ)
        begin
            manual_expose <= 1'b0;
            manual_read   <= (state == ST_MANUAL);
            if (state == ST_MANUAL)
            begin
                state <= ST_RUN;
            end
        end
        else if (field_sync_i)
        begin
            manual_read <= 1'b0;
            case (state)
                ST_ARMED:
                begin
                    if (skip_pending)
                    begin
                        skip_pending <= 1'b0; // R14
                    end
                    else if (manual_expose)
                    begin
                        state <= ST_MANUAL; // R20
                    end
                    else
                    begin
                        state       <= ST_RUN; // R13
                        field_count <= {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                ST_RUN:
                begin
                    if (field_count >= primary_max_i)
                    begin
                        state <= ST_IDLE; // R19
                    end
                    else
                    begin
                        field_count <= field_count + {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                ST_MANUAL:
                begin
                    state <= ST_MANUAL;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Masks load at the field boundary that opens the exposure
    assign mask_start = field_sync_i && state == ST_ARMED && !skip_pending
                        && !manual_expose && !primary_action_write_i; // R13

    field_mask_counter #(
        .CNT_W    (CNT_W)
    ) u_gate_mask (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (mask_start),
        .count_i  (exposure_field_count_i), // R11
        .tick_i   (field_sync_i),
        .hold_i   (state == ST_MANUAL || (state == ST_ARMED && manual_expose
                                           && !skip_pending && field_sync_i)),
        .clear_i  (force_idle || manual_read),
        .active_o (expose_active)
    );

    field_mask_counter #(
        .CNT_W    (CNT_W)
    ) u_substrate_mask (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (mask_start || read_start),
        .count_i  (expose_read_field_count_i), // R12
        .tick_i   (field_sync_i),
        .hold_i   (state == ST_MANUAL),
        .clear_i  (force_idle),
        .active_o (read_active)
    );

    // Substrate level: idle at start polarity, toggled inside pulsed lines
    always @*
    begin
        next_substrate = polarity; // R03
        if (pulse_line && !read_active) // R01 R12 R15 R18
        begin
            next_substrate = polarity ^ normal_inside; // R03
            if (last_line && fine_enabled)
            begin
                next_substrate = next_substrate ^ fine_inside; // R07
            end
        end
    end

    // The secondary counter has no port into this block
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            substrate_clock_o      <= 1'b0;
            vertical_sensor_gate_o <= 1'b0;
            primary_busy_o         <= 1'b0;
            substrate_masked_o     <= 1'b0;
            gate_masked_o          <= 1'b0;
        end
        else
        begin
            substrate_clock_o      <= next_substrate; // R16
            vertical_sensor_gate_o <= sensor_gate_i && !suppress
                                      && !expose_active; // R11 R17 R18 R16
            primary_busy_o         <= (state != ST_IDLE);
            substrate_masked_o     <= read_active;
            gate_masked_o          <= expose_active;
        end
    end

endmodule // substrate_shutter

`default_nettype wire

//--- dv/substrate_shutter_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "substrate_shutter_regs.vh"

module substrate_shutter_properties (
    // Clock and reset
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    // Timing and commands
    input wire logic                 field_sync_i,
    input wire logic                 sensor_gate_i,
    input wire logic                 primary_action_write_i,
    input wire logic [`ACTION_W-1:0] primary_action_i,
    // Outputs watched
    input wire logic                 substrate_clock_o,
    input wire logic                 vertical_sensor_gate_o,
    input wire logic                 primary_busy_o,
    input wire logic                 substrate_masked_o,
    input wire logic                 gate_masked_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_reset_quiet: assert property ($fell(rst_i) |-> !substrate_clock_o && !primary_busy_o)
        else $error("outputs not quiet after reset");
    a_gate_source: assert property (vertical_sensor_gate_o |-> $past(sensor_gate_i))
        else $error("gate output without raw gate");
    a_gate_masked: assert property (gate_masked_o [*2] |-> !vertical_sensor_gate_o)
        else $error("gate pulse while masked");
    a_sub_frozen: assert property (substrate_masked_o [*3] |-> $stable(substrate_clock_o))
        else $error("substrate moved while masked");
    a_mask_needs_busy: assert property ($rose(gate_masked_o) |-> $past(primary_busy_o))
        else $error("gate mask without active counter");
    a_mask_at_field: assert property ($rose(substrate_masked_o) |->
        $past(field_sync_i) || $past(field_sync_i, 2))
        else $error("substrate mask began off a field boundary");
    a_mask_release: assert property ($fell(substrate_masked_o) |->
        $past(field_sync_i) || $past(field_sync_i, 2) || $past(primary_action_write_i)
        || $past(primary_action_write_i, 2) || $past(primary_action_write_i, 3))
        else $error("substrate mask released off a field boundary");
    a_force_idle: assert property (primary_action_write_i && primary_action_i == 3'h7 |->
        ##3 (!primary_busy_o && !gate_masked_o && !substrate_masked_o))
        else $error("force idle left counter or masks active");
    a_busy_start: assert property (primary_action_write_i && primary_action_i == 3'h1 |->
        ##[1:2] primary_busy_o)
        else $error("counter did not start");
endmodule // substrate_shutter_properties

bind substrate_shutter substrate_shutter_properties chk_u (
    .clk_i, .rst_i, .field_sync_i, .sensor_gate_i, .primary_action_write_i,
    .primary_action_i, .substrate_clock_o, .vertical_sensor_gate_o, .primary_busy_o,
    .substrate_masked_o, .gate_masked_o
);
`default_nettype wire

//--- dv/vertical_driver_model.sv
`timescale 1ns/1ps
`default_nettype none

// Driver side: per field, counts substrate high cycles, gate pulses, first pulsed line
module vertical_driver_model (
    // Clock and timing
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        field_sync_i,
    input  wire logic        line_start_i,
    // Driven pins
    input  wire logic        substrate_clock_i,
    input  wire logic        sensor_gate_i,
    // Field report
    output logic [15:0]      hi_cnt_o,
    output logic [7:0]       gate_cnt_o,
    output logic [7:0]       first_line_o,
    output logic             done_o
);
    logic [15:0] hi;
    logic [7:0]  gates;
    logic [7:0]  first;
    logic [7:0]  line;
    logic        start_lvl;
    logic        last_gate;

    always @(posedge clk_i)
    begin
        last_gate <= sensor_gate_i;
        done_o    <= 1'b0;
        if (rst_i)
        begin
            hi    <= 16'h0000;
            gates <= 8'h00;
            first <= 8'hff;
            line  <= 8'h00;
        end
        else if (field_sync_i)
        begin
            hi_cnt_o     <= hi;
            gate_cnt_o   <= gates;
            first_line_o <= first;
            done_o       <= 1'b1;
            hi           <= {15'h0000, substrate_clock_i};
            gates        <= 8'h00;
            first        <= 8'hff;
            line         <= 8'h00;
            start_lvl    <= substrate_clock_i;
        end
        else
        begin
            hi    <= hi + {15'h0000, substrate_clock_i};
            gates <= gates + {7'h00, sensor_gate_i & ~last_gate};
            if (line_start_i)
                line <= line + 8'h01;
            if (substrate_clock_i != start_lvl && first == 8'hff)
                first <= line;
        end
    end
endmodule // vertical_driver_model
`default_nettype wire

//--- dv/substrate_shutter_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "substrate_shutter_regs.vh"

module substrate_shutter_bench;
    localparam int NPIX = 40;
    localparam int NLIN = 16;
    localparam int GL   = 2;
    logic        clk_i, rst_i, fs, ls, sg, pol, sup, fuf, skip, wr;
    logic [12:0] t1, t2, cnt, sl, f1, f2, expo, rd, a, b, c, s, g, h;
    logic [2:0]  act;
    wire         sub, vertical_sensor_gate, busy, done;
    wire  [15:0] hi;
    wire  [7:0]  gates, first;
    int          pix, line, failures, cmp_count, seed, k;

    substrate_shutter dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .field_sync_i(fs), .line_start_i(ls),
        .primary_gate_active_line_i(13'(GL)), .sensor_gate_i(sg),
        .pulse_start_polarity_i(pol), .pulse_toggle_first_i(t1), .pulse_toggle_second_i(t2),
        .pulses_per_field_i(cnt), .pulse_start_line_i(sl), .gate_suppress_i(sup),
        .fine_toggle_first_i(f1), .fine_toggle_second_i(f2), .fine_update_at_field_i(fuf),
        .exposure_field_count_i(expo), .expose_read_field_count_i(rd),
        .skip_first_mask_i(skip), .primary_max_i(13'h0014), .primary_action_write_i(wr),
        .primary_action_i(act), .substrate_clock_o(sub), .vertical_sensor_gate_o(vertical_sensor_gate),
        .primary_busy_o(busy), .substrate_masked_o(), .gate_masked_o()
    );
    vertical_driver_model drv_u (
        .clk_i(clk_i), .rst_i(rst_i), .field_sync_i(fs), .line_start_i(ls),
        .substrate_clock_i(sub), .sensor_gate_i(vertical_sensor_gate), .hi_cnt_o(hi),
        .gate_cnt_o(gates), .first_line_o(first), .done_o(done)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Field and line timing, raw gate pulse in the gate line
    always @(posedge clk_i)
    begin
        pix <= (rst_i || pix == NPIX - 1) ? 0 : pix + 1;
        if (rst_i)
            line <= 0;
        else if (pix == NPIX - 1)
            line <= (line == NLIN - 1) ? 0 : line + 1;
        fs <= !rst_i && pix == NPIX - 1 && line == NLIN - 1;
        ls <= !rst_i && pix == NPIX - 1 && line != NLIN - 1;
        sg <= !rst_i && line == GL && pix >= 5 && pix < 8;
    end

    function automatic int span(input logic [12:0] x, input logic [12:0] y);
        return (x > y) ? x - y : y - x;
    endfunction

    task automatic finish_test;
        $display("Compares %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t field value %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic check_field(input logic m_sub, input logic m_gate);
        int n;
        n = m_sub ? 0 : cnt * span(t1, t2);
        if (!m_sub && !(f1 == `FINE_TOGGLE_OFF && f2 == `FINE_TOGGLE_OFF))
            n = n + span(f1, f2);
        check(hi, 16'(pol ? NPIX * NLIN - n : n));
        check({8'h00, gates}, (m_gate || sup) ? 16'h0000 : 16'h0001);
        check({8'h00, first}, m_sub ? 16'h00ff : 16'(GL + ((sl == 0) ? 1 : sl)));
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (done !== 1'b1 && n < 2 * NPIX * NLIN);
        if (n >= 2 * NPIX * NLIN)
        begin
            failures++;
            $display("BAD %0t no field boundary seen", $time);
            finish_test;
        end
    endtask

    task automatic command(input logic [2:0] code);
        act <= code;
        wr  <= 1'b1;
        @(posedge clk_i);
        wr  <= 1'b0;
    endtask

    // New settings land at the start of a field; the field after it must show them whole
    task automatic run_cfg(input logic p, input logic [12:0] x, y, n, st, input logic u,
                           input logic [12:0] fa, fb, input logic q, input string name);
        pol <= p;
        t1  <= x;
        t2  <= y;
        cnt <= n;
        sl  <= st;
        sup <= u;
        f1  <= fa;
        f2  <= fb;
        fuf <= q;
        wait_done;
        wait_done;
        check_field(1'b0, 1'b0);
        $display("done %s", name);
    endtask

    task automatic low_speed(input logic [12:0] e, input logic [12:0] r, input logic sk);
        expo <= e;
        rd   <= r;
        skip <= sk;
        command(`ACTION_FORCE_IDLE);
        wait_done;
        command(`ACTION_SINGLE);
        for (int j = 0; j <= sk + r + 1; j++)
        begin
            wait_done;
            check_field(j >= 1 + sk && j <= sk + r, j >= 1 + sk && j <= sk + e);
        end
        $display("done low speed %0d %0d %0d", e, r, sk);
    endtask

    initial
    begin
        seed = 51;
        failures = 0;
        cmp_count = 0;
        {rst_i, fs, ls, sg, wr, act, pix, line} = {1'b1, 7'h00, 64'h0};
        {pol, t1, t2, cnt, sl, sup, fuf} = {1'b0, 13'h0004, 13'h000a, 13'h0003, 13'h0000, 2'h0};
        {f1, f2, expo, rd, skip} = {`FINE_TOGGLE_OFF, `FINE_TOGGLE_OFF, 27'h0};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_done;
        run_cfg(1'b0, 13'h0004, 13'h000a, 13'h0003, 13'h0000, 1'b0, f1, f2, 1'b0, "normal");
        run_cfg(1'b1, 13'h000c, 13'h0003, 13'h0001, 13'h0005, 1'b0, f1, f2, 1'b0, "start");
        run_cfg(1'b0, 13'h0004, 13'h000a, 13'h0003, 13'h0002, 1'b0, 13'h001e, 13'h0018, 1'b0,
                "fine at gate");
        run_cfg(1'b1, 13'h0004, 13'h000a, 13'h0004, 13'h0000, 1'b0, 13'h0015, 13'h0025, 1'b1,
                "fine at field");
        run_cfg(1'b0, 13'h0002, 13'h0013, 13'h0008, 13'h0000, 1'b1, `FINE_TOGGLE_OFF,
                `FINE_TOGGLE_OFF, 1'b0, "suppress");
        for (k = 0; k < 6; k++)
        begin
            s = 13'($unsigned($random(seed)) % 8);
            s = (s == 1) ? 13'h0000 : s;
            c = 13'(1 + $unsigned($random(seed)) % (13 - ((s == 0) ? 1 : s)));
            a = 13'(1 + $unsigned($random(seed)) % 19);
            b = 13'((a + 1 + $unsigned($random(seed)) % 18) % 20);
            g = $random(seed) & 1 ? 13'(21 + $unsigned($random(seed)) % 18) : `FINE_TOGGLE_OFF;
            h = (g == `FINE_TOGGLE_OFF) ? g : 13'(21 + $unsigned($random(seed)) % 18);
            run_cfg($random(seed) & 1, a, b, c, s, $random(seed) & 1, g, h, $random(seed) & 1,
                    "random");
        end
        run_cfg(1'b0, 13'h0004, 13'h000a, 13'h0003, 13'h0000, 1'b0, `FINE_TOGGLE_OFF,
                `FINE_TOGGLE_OFF, 1'b0, "base");
        low_speed(13'h0002, 13'h0003, 1'b0);
        low_speed(13'h0001, 13'h0002, 1'b1);
        low_speed(13'h0000, 13'h0000, 1'b0);
        command(`ACTION_FORCE_IDLE);
        wait_done;
        rd <= 13'h0002;
        command(`ACTION_MANUAL_EXPOSE);
        for (k = 0; k < 4; k++)
        begin
            wait_done;
            check_field(k > 0, k > 0);
        end
        // Readout: gate back at once, substrate masked for the rest of two fields
        command(`ACTION_MANUAL_READ);
        for (k = 0; k < 3; k++)
        begin
            wait_done;
            check_field(k < 2, 1'b0);
        end
        command(`ACTION_FORCE_IDLE);
        repeat (3) @(posedge clk_i);
        check({15'h0000, busy}, 16'h0000);
        wait_done;
        check_field(1'b0, 1'b0);
        $display("done manual");
        finish_test;
    end
endmodule // substrate_shutter_bench
`default_nettype wire
